// file: rtl/msds_top.sv
// Function
// - At power-up all four indicators light for one lamp-test interval.
// - Any internal or external error shuts the power path and motor off.
// - Internal error latches forever; supply and fault steady, directions off.
// - External error holds shutdown until a valid acknowledgment arrives.
// - Message keeps power path on, no acknowledgment, supply indicator flashes.
// - Flashing indicators toggle at 2 Hz with equal on and off time.
// - Off, ready, reverse and forward running show fixed steady patterns.
// - Overload starts 20 min cooling; fault flashes, direction steady, auto ack allowed.
// - Two minutes into overload the direction flashes; manual reset now accepted.
// - Restore failure flashes fault and both directions; manual ack after 2 min.
// - Current asymmetry trips; fault flashes, directions off, manual ack needed.
// - Over-range current beyond 2 s trips blocking; fault and direction flash.
// - With control active, phase loss, no motor or undercurrent raise a message.
// - Manual ack on rising edge; no falling edge within 2 s gives error.
// - With auto terminal linked, overload acknowledges itself after cooling.
// - Button held over 2 s gives error; over 6 s enters parameterization.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module msds_top #(
   parameter int unsigned TICK_CYCLES = msds_pkg::TICK_CYCLES,
   parameter int unsigned COOL_TICKS = msds_pkg::COOL_TICKS
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Controller and acknowledge terminals
   input wire logic ctl_fwd,
   input wire logic ctl_rev,
   input wire logic man_ack,
   input wire logic auto_link,
   input wire logic reset_button,
   // Diagnostic front end
   input wire logic diag_internal,
   input wire logic diag_overload,
   input wire logic diag_restore_fail,
   input wire logic diag_asym,
   input wire logic diag_over_max,
   input wire logic diag_phase_loss,
   input wire logic diag_no_motor,
   input wire logic diag_under_min,
   // Power path
   output logic motor_fwd,
   output logic motor_rev,
   output logic path_on,
   // Indicators, feedback, interrupt
   output logic supply_indicator,
   output logic led_fault,
   output logic led_rev,
   output logic led_fwd,
   output logic feedback,
   output logic irq
);
   localparam int unsigned TMR_W = msds_pkg::TMR_W;
   localparam int unsigned SW = msds_pkg::SHORT_W;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : hit

   // Synchronised pins
   logic [12:0] pins_s;
   msds_sync #(.W(13)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({diag_under_min, diag_no_motor, diag_phase_loss, diag_over_max, diag_asym,
          diag_restore_fail, diag_overload, diag_internal, reset_button, auto_link,
          man_ack, ctl_rev, ctl_fwd}),
      .q(pins_s)
   );
   logic s_fwd, s_rev, s_man, s_auto, s_btn, s_int, s_ovl, s_rst, s_asym, s_omax;
   logic s_ploss, s_nomot, s_under;
   assign {s_under, s_nomot, s_ploss, s_omax, s_asym, s_rst, s_ovl, s_int, s_btn, s_auto,
           s_man, s_rev, s_fwd} = pins_s;

   msds_pkg::msds_state_t state_q, state_d;
   msds_pkg::msds_kind_t kind_q, kind_d;
   logic [25:0] tick_cnt_q, tick_cnt_d;
   logic tick, flash_q, flash_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   logic [SW-1:0] man_tmr_q, man_tmr_d, btn_tmr_q, btn_tmr_d;
   logic [SW-1:0] blk_tmr_q, blk_tmr_d, und_tmr_q, und_tmr_d;
   logic man_prev_q, man_wait_q, man_wait_d, btn_prev_q;
   logic [1:0] dir_q, dir_d;
   logic msg_q, msg_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [4:0] stat_q, stat_d, mask_q, mask_d;
   logic [3:0] led_d;
   logic fwd_d, rev_d, path_d, fb_d, irq_d, pready_d, pslverr_d;
   logic [31:0] prdata_d, rd_val;
   logic man_rise, man_fall, ack_fault, btn_short, btn_err, btn_param;
   logic req_fwd, req_rev, ctl_active, ack_cmd, ack_manual, manual_ok, auto_ok, ext_trip;
   logic access, wr_en, wr_ctrl, wr_stat, wr_mask, mapped;
   logic [4:0] events;

   // Time base and flash
   always_comb begin
      tick = tick_cnt_q == 26'(TICK_CYCLES - 1);
      tick_cnt_d = tick ? 26'h0 : tick_cnt_q + 26'h1;
      flash_d = tick ? !flash_q : flash_q;
   end

   // Acknowledge sources and hold timers
   always_comb begin
      man_rise = s_man && !man_prev_q;
      man_fall = !s_man && man_prev_q;
      man_wait_d = man_wait_q;
      man_tmr_d = man_tmr_q;
      ack_fault = 1'b0;
      if (man_rise) begin
         man_wait_d = 1'b1;
         man_tmr_d = '0;
      end else if (man_fall) begin
         man_wait_d = 1'b0;
      end else if (man_wait_q && tick) begin
         man_tmr_d = man_tmr_q + SW'(1);
         if (man_tmr_d == SW'(msds_pkg::ACK_HOLD_TICKS)) begin
            ack_fault = 1'b1;
            man_wait_d = 1'b0;
         end
      end
      // Button timer saturates at the parameterization threshold
      btn_tmr_d = !s_btn ? '0 :
                  (tick && btn_tmr_q != SW'(msds_pkg::BTN_PARAM_TICKS)) ? btn_tmr_q + SW'(1) :
                  btn_tmr_q;
      btn_short = !s_btn && btn_prev_q && btn_tmr_q < SW'(msds_pkg::BTN_ERR_TICKS);
      btn_err = s_btn && tick && btn_tmr_d == SW'(msds_pkg::BTN_ERR_TICKS);
      btn_param = s_btn && tick && btn_tmr_q != btn_tmr_d &&
                  btn_tmr_d == SW'(msds_pkg::BTN_PARAM_TICKS);
      blk_tmr_d = !s_omax ? '0 :
                  (tick && blk_tmr_q <= SW'(msds_pkg::BLOCK_TICKS)) ? blk_tmr_q + SW'(1) :
                  blk_tmr_q;
      und_tmr_d = !s_under ? '0 :
                  (tick && und_tmr_q <= SW'(msds_pkg::UNDER_TICKS)) ? und_tmr_q + SW'(1) :
                  und_tmr_q;
   end

   // Sequencer
   always_comb begin
      req_fwd = s_fwd && !s_rev && ctrl_q[msds_pkg::CTRL_RUN_BIT];
      req_rev = s_rev && !s_fwd && ctrl_q[msds_pkg::CTRL_RUN_BIT];
      ctl_active = req_fwd || req_rev;
      ack_cmd = wr_ctrl && pwdata[msds_pkg::CTRL_ACK_BIT];
      ack_manual = man_rise || btn_short || ack_cmd;
      manual_ok = !(kind_q inside {msds_pkg::EK_OVERLOAD, msds_pkg::EK_RESTORE}) ||
                  tmr_q >= TMR_W'(msds_pkg::MANUAL_TICKS);
      auto_ok = kind_q == msds_pkg::EK_OVERLOAD && tmr_q >= TMR_W'(COOL_TICKS) &&
                (s_auto || ctrl_q[msds_pkg::CTRL_AUTO_BIT]);
      // Priority when several trips coincide
      kind_d = kind_q;
      ext_trip = 1'b1;
      if (s_rst) kind_d = msds_pkg::EK_RESTORE;
      else if (s_ovl) kind_d = msds_pkg::EK_OVERLOAD;
      else if (blk_tmr_q > SW'(msds_pkg::BLOCK_TICKS)) kind_d = msds_pkg::EK_BLOCK;
      else if (s_asym) kind_d = msds_pkg::EK_ASYM;
      else if (ack_fault || btn_err) kind_d = msds_pkg::EK_ACKFLT;
      else begin
         kind_d = kind_q;
         ext_trip = 1'b0;
      end
      msg_d = 1'b0;
      state_d = state_q;
      dir_d = dir_q;
      tmr_d = (tick && tmr_q != TMR_W'(COOL_TICKS)) ? tmr_q + TMR_W'(1) : tmr_q;
      if (s_int && state_q != msds_pkg::ST_LAMP) begin
         state_d = msds_pkg::ST_INT;
         kind_d = msds_pkg::EK_NONE;
         dir_d = 2'h0;
      end else begin
         unique case (state_q)
            msds_pkg::ST_LAMP: begin
               kind_d = msds_pkg::EK_NONE;
               if (tmr_q >= TMR_W'(msds_pkg::LAMP_TICKS)) state_d = msds_pkg::ST_READY;
            end
            msds_pkg::ST_READY: begin
               if (ext_trip) begin
                  state_d = msds_pkg::ST_EXT;
                  tmr_d = '0;
               end else if (btn_param) begin
                  state_d = msds_pkg::ST_PARAM;
               end else if (ctl_active) begin
                  state_d = msds_pkg::ST_RUN;
                  dir_d = {req_rev, req_fwd};
               end
            end
            msds_pkg::ST_RUN: begin
               msg_d = ctl_active && (s_ploss || s_nomot ||
                       und_tmr_q > SW'(msds_pkg::UNDER_TICKS));
               if (ext_trip) begin
                  state_d = msds_pkg::ST_EXT;
                  tmr_d = '0;
                  msg_d = 1'b0;
               end else if ({req_rev, req_fwd} != dir_q) begin
                  state_d = msds_pkg::ST_READY;
                  dir_d = 2'h0;
                  msg_d = 1'b0;
               end
            end
            msds_pkg::ST_EXT: begin
               kind_d = kind_q;
               if (btn_param && kind_q == msds_pkg::EK_ACKFLT) begin
                  // A long hold passes the 2 s button error on its way here
                  state_d = msds_pkg::ST_PARAM;
                  kind_d = msds_pkg::EK_NONE;
                  dir_d = 2'h0;
               end else if ((ack_manual && manual_ok) || auto_ok) begin
                  state_d = msds_pkg::ST_READY;
                  kind_d = msds_pkg::EK_NONE;
                  dir_d = 2'h0;
               end
            end
            msds_pkg::ST_INT: begin
               state_d = msds_pkg::ST_INT;
               kind_d = msds_pkg::EK_NONE;
            end
            msds_pkg::ST_PARAM: begin
               kind_d = msds_pkg::EK_NONE;
               if (btn_short) state_d = msds_pkg::ST_READY;
            end
            default: begin
               state_d = msds_pkg::ST_INT;
               kind_d = msds_pkg::EK_NONE;
            end
         endcase
      end
      if (state_d != state_q) tmr_d = '0;
      // Outputs follow the next state so they never lag the sequencer
      fwd_d = state_d == msds_pkg::ST_RUN && dir_d == 2'h1;
      rev_d = state_d == msds_pkg::ST_RUN && dir_d == 2'h2;
      path_d = state_d == msds_pkg::ST_RUN;
      fb_d = state_d inside {msds_pkg::ST_EXT, msds_pkg::ST_INT} || msg_d;
   end

   // Indicator pattern {supply, fault, reverse, forward}
   always_comb begin
      unique case (state_q)
         msds_pkg::ST_LAMP: led_d = 4'hF;
         msds_pkg::ST_READY: led_d = 4'h8;
         msds_pkg::ST_RUN: led_d = {msg_q ? flash_q : 1'b1, msg_q && flash_q, dir_q};
         msds_pkg::ST_INT: led_d = 4'hC;
         msds_pkg::ST_PARAM: led_d = ctrl_q[msds_pkg::CTRL_NOM_LSB +: 4];
         msds_pkg::ST_EXT: begin
            unique case (kind_q)
               msds_pkg::EK_OVERLOAD: led_d = {1'b1, flash_q, manual_ok ? dir_q & {2{flash_q}} : dir_q};
               msds_pkg::EK_RESTORE: led_d = {1'b1, flash_q, flash_q, flash_q};
               msds_pkg::EK_BLOCK: led_d = {1'b1, flash_q, dir_q & {2{flash_q}}};
               default: led_d = {1'b1, flash_q, 2'h0};
            endcase
         end
         default: led_d = 4'hC;
      endcase
   end

   // APB slave: one wait state, pready and data from flops
   always_comb begin
      access = psel && penable;
      wr_en = access && pready && pwrite;
      wr_ctrl = wr_en && hit(paddr, msds_pkg::ADDR_CTRL);
      wr_stat = wr_en && hit(paddr, msds_pkg::ADDR_INT_STAT);
      wr_mask = wr_en && hit(paddr, msds_pkg::ADDR_INT_MASK);
      mapped = hit(paddr, msds_pkg::ADDR_CTRL) || hit(paddr, msds_pkg::ADDR_STATE) ||
               hit(paddr, msds_pkg::ADDR_INT_STAT) || hit(paddr, msds_pkg::ADDR_INT_MASK);
      rd_val = 32'h0;
      if (hit(paddr, msds_pkg::ADDR_CTRL)) rd_val = {24'h0, ctrl_q};
      else if (hit(paddr, msds_pkg::ADDR_INT_STAT)) rd_val = {27'h0, stat_q};
      else if (hit(paddr, msds_pkg::ADDR_INT_MASK)) rd_val = {27'h0, mask_q};
      else if (hit(paddr, msds_pkg::ADDR_STATE)) begin
         rd_val[msds_pkg::STATE_ST_LSB +: 6] = state_q;
         rd_val[msds_pkg::STATE_KIND_LSB +: 3] = kind_q;
         rd_val[msds_pkg::STATE_MSG_BIT] = msg_q;
         rd_val[msds_pkg::STATE_DIR_LSB +: 2] = dir_q;
         rd_val[msds_pkg::STATE_LED_LSB +: 4] = {supply_indicator, led_fault, led_rev, led_fwd};
      end
      pready_d = access && !pready;
      pslverr_d = pready_d && !mapped;
      prdata_d = (pready_d && !pwrite) ? rd_val : 32'h0;
      ctrl_d = ctrl_q;
      if (wr_ctrl) ctrl_d = pwdata[7:0] & ~(8'h1 << msds_pkg::CTRL_ACK_BIT);
      mask_d = wr_mask ? pwdata[4:0] : mask_q;
      events = '0;
      events[msds_pkg::IRQ_EXT] = state_d == msds_pkg::ST_EXT && state_q != msds_pkg::ST_EXT;
      events[msds_pkg::IRQ_INT] = state_d == msds_pkg::ST_INT && state_q != msds_pkg::ST_INT;
      events[msds_pkg::IRQ_MSG] = msg_d && !msg_q;
      events[msds_pkg::IRQ_ACK] = state_q == msds_pkg::ST_EXT && state_d == msds_pkg::ST_READY;
      events[msds_pkg::IRQ_PARAM] = state_d == msds_pkg::ST_PARAM && state_q != msds_pkg::ST_PARAM;
      // Set wins over a clear in the same cycle
      stat_d = (stat_q & ~(wr_stat ? pwdata[4:0] : 5'h00)) | events;
      irq_d = |(stat_d & mask_d);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= msds_pkg::ST_LAMP;
         kind_q <= msds_pkg::EK_NONE;
         tick_cnt_q <= 26'h0;
         flash_q <= 1'b0;
         tmr_q <= '0;
         man_tmr_q <= '0;
         btn_tmr_q <= '0;
         blk_tmr_q <= '0;
         und_tmr_q <= '0;
         man_prev_q <= 1'b0;
         man_wait_q <= 1'b0;
         btn_prev_q <= 1'b0;
         dir_q <= 2'h0;
         msg_q <= 1'b0;
         ctrl_q <= msds_pkg::CTRL_RESET;
         stat_q <= 5'h00;
         mask_q <= msds_pkg::INT_MASK_RESET;
         motor_fwd <= 1'b0;
         motor_rev <= 1'b0;
         path_on <= 1'b0;
         {supply_indicator, led_fault, led_rev, led_fwd} <= 4'h0;
         feedback <= 1'b0;
         irq <= 1'b0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         tick_cnt_q <= tick_cnt_d;
         flash_q <= flash_d;
         tmr_q <= tmr_d;
         man_tmr_q <= man_tmr_d;
         btn_tmr_q <= btn_tmr_d;
         blk_tmr_q <= blk_tmr_d;
         und_tmr_q <= und_tmr_d;
         man_prev_q <= s_man;
         man_wait_q <= man_wait_d;
         btn_prev_q <= s_btn;
         dir_q <= dir_d;
         msg_q <= msg_d;
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         motor_fwd <= fwd_d;
         motor_rev <= rev_d;
         path_on <= path_d;
         {supply_indicator, led_fault, led_rev, led_fwd} <= led_d;
         feedback <= fb_d;
         irq <= irq_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_no_both_dir: assert property (!(motor_fwd && motor_rev))
      else $error("forward and reverse driven together");
   a_dir_via_off: assert property ($rose(motor_rev) |-> $past(!motor_fwd, 1))
      else $error("reverse rose straight from forward");
   a_err_path_off: assert property (
      state_q inside {msds_pkg::ST_EXT, msds_pkg::ST_INT}
      |-> !path_on && !motor_fwd && !motor_rev)
      else $error("power path on during error");
   a_int_latched: assert property (
      state_q == msds_pkg::ST_INT |=> state_q == msds_pkg::ST_INT
      ##1 {supply_indicator, led_fault, led_rev, led_fwd} == 4'hC)
      else $error("internal error left or wrong indicators");
   a_ext_holds: assert property (
      state_q == msds_pkg::ST_EXT && !ack_manual && !auto_ok && !s_int && !btn_param
      |=> state_q == msds_pkg::ST_EXT)
      else $error("external error left without acknowledgment");
   a_msg_path_on: assert property (msg_q |-> path_on && feedback)
      else $error("message dropped power path or feedback");
   a_flash_toggle: assert property (tick |=> flash_q != $past(flash_q))
      else $error("flash did not toggle on tick");
   a_lamp_leds: assert property (
      state_q == msds_pkg::ST_LAMP |=> {supply_indicator, led_fault, led_rev, led_fwd} == 4'hF)
      else $error("lamp test not all on");
   a_ready_leds: assert property (
      state_q == msds_pkg::ST_READY |=> {supply_indicator, led_fault, led_rev, led_fwd} == 4'h8)
      else $error("ready pattern wrong");
   a_early_manual: assert property (
      state_q == msds_pkg::ST_EXT && kind_q == msds_pkg::EK_OVERLOAD
      && tmr_q < TMR_W'(msds_pkg::MANUAL_TICKS) && !s_int |=> state_q == msds_pkg::ST_EXT)
      else $error("overload acknowledged before two minutes");
   a_asym_dirs_off: assert property (
      state_q == msds_pkg::ST_EXT && kind_q == msds_pkg::EK_ASYM
      |=> !led_rev && !led_fwd && supply_indicator)
      else $error("asymmetry shows a direction");
   a_feedback_err: assert property (
      state_q inside {msds_pkg::ST_EXT, msds_pkg::ST_INT} |-> feedback)
      else $error("feedback low during error");

   c_lamp_done: cover property (state_q == msds_pkg::ST_LAMP ##1 state_q == msds_pkg::ST_READY);
   c_ext_ack: cover property (state_q == msds_pkg::ST_EXT ##1 state_q == msds_pkg::ST_READY);
   c_message: cover property ($rose(msg_q));
   c_param: cover property ($rose(state_q == msds_pkg::ST_PARAM));
endmodule : msds_top

// file: rtl/msds_pkg.sv
package msds_pkg;

   // Clock and time base
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
   // One tick is half a flash period, so 2 Hz flashing toggles on every tick
   localparam int unsigned TICK_MS = 250;
   localparam int unsigned TICK_CYCLES = CLK_PER_MS * TICK_MS;

   // Times in their own units
   localparam int unsigned LAMP_MS = 1000;
   localparam int unsigned ACK_HOLD_S = 2;
   localparam int unsigned BTN_ERR_S = 2;
   localparam int unsigned BTN_PARAM_S = 6;
   localparam int unsigned BLOCK_S = 2;
   localparam int unsigned UNDER_S = 2;
   localparam int unsigned MANUAL_S = 120;
   localparam int unsigned COOL_S = 1200;

   // Derived counts in ticks
   localparam int unsigned LAMP_TICKS = LAMP_MS / TICK_MS;
   localparam int unsigned ACK_HOLD_TICKS = ACK_HOLD_S * 1000 / TICK_MS;
   localparam int unsigned BTN_ERR_TICKS = BTN_ERR_S * 1000 / TICK_MS;
   localparam int unsigned BTN_PARAM_TICKS = BTN_PARAM_S * 1000 / TICK_MS;
   localparam int unsigned BLOCK_TICKS = BLOCK_S * 1000 / TICK_MS;
   localparam int unsigned UNDER_TICKS = UNDER_S * 1000 / TICK_MS;
   localparam int unsigned MANUAL_TICKS = MANUAL_S * 1000 / TICK_MS;
   localparam int unsigned COOL_TICKS = COOL_S * 1000 / TICK_MS;
   localparam int unsigned TMR_W = 13;
   localparam int unsigned SHORT_W = 5;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATE = 8'h04;
   localparam logic [7:0] ADDR_INT_STAT = 8'h08;
   localparam logic [7:0] ADDR_INT_MASK = 8'h0C;

   // Control register fields
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_AUTO_BIT = 1;
   localparam int unsigned CTRL_ACK_BIT = 2;
   localparam int unsigned CTRL_NOM_LSB = 4;
   localparam logic [7:0] CTRL_RESET = 8'h01;

   // State register fields
   localparam int unsigned STATE_ST_LSB = 0;
   localparam int unsigned STATE_KIND_LSB = 8;
   localparam int unsigned STATE_MSG_BIT = 12;
   localparam int unsigned STATE_DIR_LSB = 13;
   localparam int unsigned STATE_LED_LSB = 16;

   // Interrupt status and mask fields
   localparam int unsigned IRQ_W = 5;
   localparam int unsigned IRQ_EXT = 0;
   localparam int unsigned IRQ_INT = 1;
   localparam int unsigned IRQ_MSG = 2;
   localparam int unsigned IRQ_ACK = 3;
   localparam int unsigned IRQ_PARAM = 4;
   localparam logic [4:0] INT_MASK_RESET = 5'h00;

   typedef enum logic [5:0] {
      ST_LAMP = 6'h01,
      ST_READY = 6'h02,
      ST_RUN = 6'h04,
      ST_EXT = 6'h08,
      ST_INT = 6'h10,
      ST_PARAM = 6'h20
   } msds_state_t;

   typedef enum logic [2:0] {
      EK_NONE = 3'h0,
      EK_OVERLOAD = 3'h1,
      EK_RESTORE = 3'h2,
      EK_ASYM = 3'h3,
      EK_BLOCK = 3'h4,
      EK_ACKFLT = 3'h5
   } msds_kind_t;

endpackage : msds_pkg

// file: rtl/msds_sync.sv
`timescale 1ns/1ps
module msds_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous in, synchronous out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : msds_sync

// file: dv/msds_ctrl_model.sv
`timescale 1ns/1ps
module msds_ctrl_model #(
   parameter int HOLD = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Commands from the bench
   input wire logic [1:0] req_dir,
   input wire logic ack_go,
   // Controller terminals
   output logic ctl_fwd,
   output logic ctl_rev,
   output logic man_ack
);
   int cnt;
   // Short press only, so a stuck contact is never mimicked by accident
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_fwd <= 1'b0;
         ctl_rev <= 1'b0;
         man_ack <= 1'b0;
         cnt <= 0;
      end else begin
         ctl_fwd <= req_dir == 2'h1;
         ctl_rev <= req_dir == 2'h2;
         if (ack_go && cnt == 0) begin
            man_ack <= 1'b1;
            cnt <= HOLD;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
            man_ack <= cnt > 1;
         end
      end
   end
endmodule : msds_ctrl_model

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd, seed = 32'h718E7B7D;
   logic pready, pslverr, err, ctl_fwd, ctl_rev, man_ack, ack_go = 1'b0, btn = 1'b0;
   logic [1:0] req_dir = 2'h0;
   logic [8:0] diag = 9'h000;
   logic [4:0] msk;
   logic motor_fwd, motor_rev, path_on, sup, lf, lr, lfw, feedback, irq;
   int n_mismatch = 0, num_checks = 0, exp_state;
   initial forever #2.5 pclk = ~pclk;
   msds_ctrl_model ctl_u (.pclk(pclk), .presetn(presetn), .req_dir(req_dir), .ack_go(ack_go),
      .ctl_fwd(ctl_fwd), .ctl_rev(ctl_rev), .man_ack(man_ack));
   msds_top #(.TICK_CYCLES(4), .COOL_TICKS(600)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctl_fwd(ctl_fwd),
      .ctl_rev(ctl_rev), .man_ack(man_ack), .auto_link(diag[7]), .reset_button(btn),
      .diag_internal(diag[0]), .diag_overload(diag[1]), .diag_restore_fail(diag[8]),
      .diag_asym(diag[2]), .diag_over_max(diag[3]), .diag_phase_loss(diag[4]),
      .diag_no_motor(diag[5]), .diag_under_min(diag[6]), .motor_fwd(motor_fwd),
      .motor_rev(motor_rev), .path_on(path_on), .supply_indicator(sup), .led_fault(lf),
      .led_rev(lr), .led_fwd(lfw), .feedback(feedback), .irq(irq));
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_pin(input logic [5:0] got, input logic [5:0] exp);
      chk_word({26'h0, got}, {26'h0, exp});
   endtask : chk_pin
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk_state(input logic [31:0] m);
      apb(1'b0, 8'h04, 32'h0);
      chk_word(rd & m, exp_state & m);
   endtask : chk_state
   initial begin
      wt(20000);
      n_mismatch++;
      close_out();
   end
   initial begin
      wt(8);
      presetn <= 1'b1;
      wt(4);
      chk_pin({lfw, lr, lf, sup, 2'h0}, 6'h3C);
      wt(40);
      exp_state = 32'h80002;
      chk_state(32'hF003F);
      chk_pin({sup, lf, lr, lfw, feedback, path_on}, 6'h20);
      apb(1'b0, 8'h40, 32'h0);
      chk_word({rd[31:1], err}, 32'h1);
      msk = 5'($random(seed));
      apb(1'b1, 8'h0C, {27'h0, msk | 5'h05});
      apb(1'b0, 8'h0C, 32'h0);
      chk_word(rd, {27'h0, msk | 5'h05});
      req_dir <= 2'h1;
      wt(12);
      exp_state = 32'h90004;
      chk_state(32'hF003F);
      chk_pin({motor_fwd, motor_rev, path_on, 3'h0}, 6'h28);
      diag[5] <= 1'b1;
      wt(12);
      chk_pin({path_on, feedback, 4'h0}, 6'h30);
      chk_pin({sup ^ lf, lr, lfw, 3'h0}, 6'h08);
      exp_state = 32'h1004;
      chk_state(32'h103F);
      diag[5] <= 1'b0;
      diag[1] <= 1'b1;
      wt(10);
      chk_pin({motor_fwd, path_on, feedback, irq, 2'h0}, 6'h0C);
      diag[1] <= 1'b0;
      req_dir <= 2'h0;
      exp_state = 32'h108;
      chk_state(32'h73F);
      chk_pin({sup, lr, lfw, 3'h0}, 6'h28);
      apb(1'b1, 8'h08, 32'h1F);
      wt(3);
      chk_pin({irq, 5'h0}, 6'h0);
      ack_go <= 1'b1;
      wt(40);
      chk_state(32'h73F);
      ack_go <= 1'b0;
      wt(2000);
      chk_pin({lf ^ lfw, 5'h0}, 6'h00);
      wt(4);
      chk_pin({lf ^ lfw, 5'h0}, 6'h00);
      ack_go <= 1'b1;
      wt(40);
      ack_go <= 1'b0;
      exp_state = 32'h80002;
      chk_state(32'hF003F);
      btn <= 1'b1;
      wt(50);
      exp_state = 32'h508;
      chk_state(32'h73F);
      wt(60);
      exp_state = 32'h20;
      chk_state(32'h3F);
      btn <= 1'b0;
      wt(10);
      btn <= 1'b1;
      wt(8);
      btn <= 1'b0;
      wt(10);
      exp_state = 32'h80002;
      chk_state(32'hF003F);
      diag[8] <= 1'b1;
      wt(10);
      diag[8] <= 1'b0;
      exp_state = 32'h208;
      chk_state(32'h73F);
      chk_pin({sup, lf ^ lr, lf ^ lfw, 3'h0}, 6'h20);
      ack_go <= 1'b1;
      wt(40);
      ack_go <= 1'b0;
      chk_state(32'h73F);
      wt(2000);
      ack_go <= 1'b1;
      wt(40);
      ack_go <= 1'b0;
      exp_state = 32'h80002;
      chk_state(32'hF003F);
      diag[2] <= 1'b1;
      wt(10);
      diag[2] <= 1'b0;
      exp_state = 32'h308;
      chk_state(32'h73F);
      chk_pin({sup, lr, lfw, 3'h0}, 6'h20);
      ack_go <= 1'b1;
      wt(40);
      ack_go <= 1'b0;
      exp_state = 32'h80002;
      chk_state(32'hF003F);
      diag[0] <= 1'b1;
      wt(10);
      diag[0] <= 1'b0;
      ack_go <= 1'b1;
      wt(40);
      exp_state = 32'hC0010;
      chk_state(32'hF003F);
      chk_pin({irq, path_on, 4'h0}, 6'h20);
      close_out();
   end
endmodule : testbench
